// ---- saw_pkg.sv ----
// constants, register map and timing for the sleep-aware watchdog timer
`default_nettype none

package saw_pkg;
   // ----------------------------------------------------------------
   // clock rates
   // ----------------------------------------------------------------
   localparam int CORE_CLK_HZ = 100_000_000;
   localparam int LF_OSC_HZ = 31_000;
   localparam int LF_DIV_CYCLES = CORE_CLK_HZ / LF_OSC_HZ;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] EVT_OFS = 4'h1;
   localparam logic [3:0] MASK_OFS = 4'h2;
   localparam logic [3:0] FLAG_OFS = 4'h3;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int PER_LSB = 1;
   localparam int PER_MSB = 5;
   localparam int SWEN_BIT = 0;
   localparam logic [4:0] PER_RESET = 5'h0B;
   localparam logic SWEN_RESET = 1'b0;
   localparam logic [4:0] PER_MAX_CODE = 5'h12;
   localparam logic [4:0] PER_SHIFT_BASE = 5'h05;
   localparam int EVT_RST_BIT = 0;
   localparam int EVT_WAKE_BIT = 1;
   localparam int FLAG_TO_BIT = 0;
   localparam int FLAG_PD_BIT = 1;
   localparam int FLAG_WATCHDOG_RESET_FLAG_BIT = 2;
   localparam int FLAG_SLEEP_BIT = 3;
   localparam int FLAG_ACT_BIT = 4;

   // ----------------------------------------------------------------
   // mode select encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SOFT = 2'h1;
   localparam logic [1:0] MODE_NOSLEEP = 2'h2;
   localparam logic [1:0] MODE_ON = 2'h3;
endpackage

`default_nettype wire

// ---- saw_watchdog.sv ----
// sleep-aware watchdog timer with register port and interrupt
`default_nettype none

module saw_watchdog
   import saw_pkg::*;
#(
   parameter int LF_DIV = LF_DIV_CYCLES
) (
   input wire logic i_core_clk, // 100 MHz core clock
   input wire logic i_resetn, // async reset, active low
   input wire logic [1:0] i_watchdog_mode_select, // config word mode
   input wire logic i_watchdog_clear_instr, // clear pulse from core
   input wire logic i_sleep_enter, // sleep entry pulse
   input wire logic i_sleep_exit, // sleep exit pulse
   input wire logic i_osc_fail, // oscillator fail pulse
   input wire logic [3:0] i_reg_addr, // register address
   input wire logic [7:0] i_reg_wdata, // register write data
   input wire logic i_reg_wr, // write strobe
   input wire logic i_reg_rd, // read strobe
   output logic [7:0] o_reg_rdata, // read data, cycle after strobe
   output logic o_system_reset, // one-cycle reset request
   output logic o_wake, // one-cycle wake request
   output logic o_timeout_status_flag_n, // low after a timeout
   output logic o_powerdown_status_flag_n, // low after sleep entry
   output logic o_watchdog_reset_flag, // high after watchdog reset
   output logic o_irq // level interrupt
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] per;
      logic swen;
      logic [11:0] div;
      logic [23:0] cnt;
      logic asleep;
      logic to_n;
      logic pd_n;
      logic watchdog_reset_flag;
      logic [1:0] evt;
      logic [1:0] mask;
      logic [7:0] rdata;
      logic rst_pls;
      logic wake_pls;
   } saw_state_t;

   saw_state_t q;
   saw_state_t d;
   logic tick;
   logic active;
   logic clear;
   logic timeout;
   logic enter;
   logic leave;
   logic [4:0] shift;
   logic [23:0] limit;

   // ----------------------------------------------------------------
   // mode decode and period limit
   // ----------------------------------------------------------------
   always_comb begin
      case (i_watchdog_mode_select)
         MODE_ON: active = 1'b1;
         MODE_NOSLEEP: active = !q.asleep;
         MODE_SOFT: active = q.swen;
         default: active = 1'b0;
      endcase
   end

   // reserved codes fall back to the shortest interval
   assign shift = (q.per > PER_MAX_CODE) ? PER_SHIFT_BASE : 5'(q.per + PER_SHIFT_BASE);
   assign limit = 24'((25'h1 << shift) - 25'h1);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.rst_pls = 1'b0;
      d.wake_pls = 1'b0;
      d.rdata = 8'h00;
      // low-frequency oscillator modelled as a free-running enable
      tick = (q.div == 12'(LF_DIV - 1));
      d.div = tick ? 12'h000 : 12'(q.div + 12'h001);
      enter = i_sleep_enter && !q.asleep;
      leave = i_sleep_exit && q.asleep;
      // a clear in the same cycle as the terminal count wins
      clear = !active || i_watchdog_clear_instr || enter || leave || i_osc_fail;
      // at-or-above so shortening the period under a high count still times out
      timeout = active && tick && (q.cnt >= limit) && !clear;
      // counter sees only the oscillator tick; no divider select term
      if (clear) begin
         d.cnt = 24'h000000;
      end else if (timeout) begin
         d.cnt = 24'h000000;
      end else if (tick) begin
         d.cnt = 24'(q.cnt + 24'h000001);
      end
      if (enter) begin
         d.asleep = 1'b1;
         d.pd_n = 1'b0;
         d.to_n = 1'b1;
      end
      if (leave) begin
         d.asleep = 1'b0;
      end
      if (i_watchdog_clear_instr) begin
         d.to_n = 1'b1;
         d.pd_n = 1'b1;
      end
      // register writes first so hardware events override clears
      if (i_reg_wr) begin
         if (i_reg_addr == CTRL_OFS) begin
            d.per = i_reg_wdata[PER_MSB:PER_LSB];
            d.swen = i_reg_wdata[SWEN_BIT];
         end else if (i_reg_addr == EVT_OFS) begin
            d.evt = q.evt & ~i_reg_wdata[1:0];
         end else if (i_reg_addr == MASK_OFS) begin
            d.mask = i_reg_wdata[1:0];
         end else if (i_reg_addr == FLAG_OFS) begin
            if (i_reg_wdata[FLAG_WATCHDOG_RESET_FLAG_BIT]) begin
               d.watchdog_reset_flag = 1'b0;
            end
         end
      end
      if (timeout) begin
         d.to_n = 1'b0;
         if (q.asleep) begin
            d.wake_pls = 1'b1;
            d.asleep = 1'b0;
            d.evt[EVT_WAKE_BIT] = 1'b1;
         end else begin
            d.rst_pls = 1'b1;
            d.watchdog_reset_flag = 1'b1;
            d.evt[EVT_RST_BIT] = 1'b1;
         end
      end
      if (i_reg_rd) begin
         if (i_reg_addr == CTRL_OFS) begin
            d.rdata = {2'b00, q.per, q.swen};
         end else if (i_reg_addr == EVT_OFS) begin
            d.rdata = {6'h00, q.evt};
         end else if (i_reg_addr == MASK_OFS) begin
            d.rdata = {6'h00, q.mask};
         end else if (i_reg_addr == FLAG_OFS) begin
            d.rdata = {3'b000, active, q.asleep, q.watchdog_reset_flag, q.pd_n, q.to_n};
         end else begin
            d.rdata = 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= '0;
         q.per <= PER_RESET;
         q.swen <= SWEN_RESET;
         q.to_n <= 1'b1;
         q.pd_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_reg_rdata = q.rdata;
   assign o_system_reset = q.rst_pls;
   assign o_wake = q.wake_pls;
   assign o_timeout_status_flag_n = q.to_n;
   assign o_powerdown_status_flag_n = q.pd_n;
   assign o_watchdog_reset_flag = q.watchdog_reset_flag;
   assign o_irq = |(q.evt & q.mask);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);

   awake_reset_a: assert property (timeout && !q.asleep |=> o_system_reset && !o_wake)
      else $error("awake timeout gave no reset");
   sleep_wake_a: assert property (timeout && q.asleep |=> o_wake && !o_system_reset)
      else $error("sleep timeout did not wake");
   mode_on_a: assert property (i_watchdog_mode_select == MODE_ON |-> active)
      else $error("mode 11 not active");
   nosleep_off_a: assert property (i_watchdog_mode_select == MODE_NOSLEEP && q.asleep |-> !active)
      else $error("mode 10 active in sleep");
   soft_follow_a: assert property (i_watchdog_mode_select == MODE_SOFT |-> active == q.swen)
      else $error("mode 01 ignores soft enable");
   disabled_clear_a: assert property (!active |=> q.cnt == 24'h000000)
      else $error("disabled counter not cleared");
   clear_instr_a: assert property (i_watchdog_clear_instr |=> q.cnt == 24'h000000)
      else $error("clear instruction ignored");
   sleep_entry_a: assert property (enter |=> q.asleep && q.cnt == 24'h000000 && !q.pd_n)
      else $error("sleep entry handling wrong");
   tick_only_a: assert property (!tick && !clear |=> $stable(q.cnt))
      else $error("counter moved without tick");
   reserved_per_a: assert property (q.per > PER_MAX_CODE |-> limit == 24'h00001F)
      else $error("reserved code not 1:32");
   timeout_flag_a: assert property (o_system_reset |-> o_watchdog_reset_flag && !o_timeout_status_flag_n)
      else $error("timeout flags not updated");
   ctrl_read_a: assert property (i_reg_rd && i_reg_addr == CTRL_OFS |=> o_reg_rdata[7:6] == 2'b00 && o_reg_rdata[5:1] == $past(q.per))
      else $error("control read wrong");

   reset_seen_c: cover property (o_system_reset);
   wake_seen_c: cover property (o_wake);
   kick_c: cover property (i_watchdog_clear_instr && active && q.cnt != 24'h000000);
   irq_c: cover property (o_irq);

endmodule

`default_nettype wire

// ---- saw_core_model.sv ----
// cpu core model: turns bench commands into core event pulses, one core cycle later
`default_nettype none

module saw_core_model
   import saw_pkg::*;
(
   input wire logic i_core_clk, // core clock
   input wire logic i_resetn, // async reset, active low
   input wire logic [1:0] i_cmd, // 1 clear, 2 sleep entry, 3 sleep exit
   output logic o_clear, // clear instruction pulse
   output logic o_enter, // sleep entry pulse
   output logic o_exit // sleep exit pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // registered, so every event follows its command one core cycle later and is as wide as the command
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         {o_clear, o_enter, o_exit} <= 3'h0;
      end else begin
         o_clear <= i_cmd == 2'h1;
         o_enter <= i_cmd == 2'h2;
         o_exit <= i_cmd == 2'h3;
      end
   end
endmodule

`default_nettype wire

// ---- sleep_aware_watchdog_timer_tb.sv ----
// self-checking bench for the sleep-aware watchdog timer
`default_nettype none

module sleep_aware_watchdog_timer_tb
   import saw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 4;
   logic clk, rstn, fail, wr, rd, clr, ent, ext, srst, wake, to_n, pd_n, watchdog_reset_flag, irq;
   logic [1:0] mode, cmd;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   int err_count = 0, compares = 0, cycles = 0, n;
   logic [4:0] codes[4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
   int ticks[4] = '{32, 64, 32, 32};

   saw_core_model saw_core_model_inst (.i_core_clk(clk), .i_resetn(rstn), .i_cmd(cmd),
      .o_clear(clr), .o_enter(ent), .o_exit(ext));
   saw_watchdog #(.LF_DIV(DIV)) saw_watchdog_inst (.i_core_clk(clk), .i_resetn(rstn),
      .i_watchdog_mode_select(mode), .i_watchdog_clear_instr(clr), .i_sleep_enter(ent),
      .i_sleep_exit(ext), .i_osc_fail(fail), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_system_reset(srst),
      .o_wake(wake), .o_timeout_status_flag_n(to_n), .o_powerdown_status_flag_n(pd_n),
      .o_watchdog_reset_flag(watchdog_reset_flag), .o_irq(irq));

   // ----------------------------------------------------------------
   // clock, hang guard, closing
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic check(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input string msg);
      @(posedge clk);
      {rd, addr} <= {1'b1, a};
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata === e, msg);
   endtask
   task automatic core(input logic [1:0] c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 2'h0;
   endtask
   // cycles until the chosen pulse, or lim if it never comes
   task automatic watch(input bit w, input int lim);
      n = 0;
      while (n < lim && (w ? wake : srst) !== 1'b1) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   task automatic near(input int t, input string msg);
      check(n >= t * DIV - 8 && n <= t * DIV + 8, msg);
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {rstn, fail, wr, rd, cmd, addr, wdata} = '0;
      mode = MODE_ON;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(CTRL_OFS, 8'h16, "ctrl reset value");
      rd_reg(FLAG_OFS, 8'h13, "flags reset value");
      rd_reg(4'h4, 8'h00, "unmapped read");
      wr_reg(CTRL_OFS, 8'hFF);
      rd_reg(CTRL_OFS, 8'h3F, "ctrl upper bits");
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         wr_reg(CTRL_OFS, {2'h0, codes[i], 1'b0});
         core(2'h1);
         watch(0, 400);
         near(ticks[i], "awake timeout period");
      end
      rd_reg(FLAG_OFS, 8'h16, "flags after reset timeout");
      check(watchdog_reset_flag === 1'b1 && to_n === 1'b0 && pd_n === 1'b1, "reset flag pins");
      wr_reg(MASK_OFS, 8'h01);
      @(posedge clk);
      #1 check(irq === 1'b1, "irq unmasked");
      wr_reg(EVT_OFS, 8'h01);
      @(posedge clk);
      #1 check(irq === 1'b0, "irq after clear");
      wr_reg(FLAG_OFS, 8'h04);
      #1 check(watchdog_reset_flag === 1'b0, "reset flag cleared");
      $display("period and irq done");
      core(2'h2);
      watch(1, 400);
      near(32, "sleep wake in always-on");
      rd_reg(FLAG_OFS, 8'h10, "flags after wake");
      check(to_n === 1'b0 && pd_n === 1'b0 && watchdog_reset_flag === 1'b0, "wake flag pins");
      mode <= MODE_NOSLEEP;
      core(2'h2);
      watch(1, 400);
      check(n == 400, "no wake when off in sleep");
      core(2'h3);
      watch(0, 400);
      near(32, "timeout after sleep exit");
      mode <= MODE_OFF;
      core(2'h1);
      watch(0, 400);
      check(n == 400, "mode off quiet");
      check(to_n === 1'b1 && pd_n === 1'b1, "clear sets flag pins");
      mode <= MODE_SOFT;
      core(2'h1);
      watch(0, 400);
      check(n == 400, "soft enable low quiet");
      wr_reg(CTRL_OFS, 8'h01);
      core(2'h1);
      watch(0, 400);
      near(32, "soft enable high");
      core(2'h2);
      watch(1, 400);
      near(32, "soft enable in sleep");
      $display("modes done");
      mode <= MODE_ON;
      core(2'h1);
      repeat (100) @(posedge clk);
      fail <= 1'b1;
      @(posedge clk);
      fail <= 1'b0;
      watch(0, 400);
      near(32, "osc fail clears counter");
      $display("osc fail done");
      close_out();
   end
endmodule

`default_nettype wire
